// ===== verification/socf_assertions.sv
`timescale 1ns/1ps
module socf_chk
  import socf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [11:0] factory_quiescent,
  input wire logic [11:0] field_response,
  input wire logic field_valid,
  input wire logic [11:0] output_level,
  input wire logic output_valid,
  input wire logic output_protocol_select,
  input wire logic [2:0] output_slew_select,
  input wire logic overvoltage_threshold_select
);
  logic tset;
  logic [11:0] trim;
  wire wr = psel && penable && !pready && pwrite;
  wire [11:0] base = tset ? trim : factory_quiescent;
  wire [12:0] sum = {field_response[11], field_response} + {base[11], base};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // shadow of the baseline choice; trim is only used once it is set
  always_ff @(posedge ref_clk) begin
    if (rst) tset <= 1'b0;
    else if (wr && paddr == QTRIM_ADDR) tset <= 1'b1;
    else if (wr && paddr == QSET_ADDR) tset <= pwdata[0];
    if (rst) trim <= QTRIM_RST;
    else if (wr && paddr == QTRIM_ADDR) trim <= pwdata[11:0];
  end
  AST_PROTO: assert property (wr && paddr == MODE_ADDR |=>
    output_protocol_select == $past(pwdata[PROTO_BIT])) else $error("mode");
  AST_OVLO: assert property (wr && paddr == MODE_ADDR |=>
    overvoltage_threshold_select == $past(pwdata[OVLO_BIT])) else $error("ov");
  AST_SLEW: assert property (wr && paddr == SLEW_ADDR |=>
    output_slew_select == $past(pwdata[SLEW_LSB+:SLEW_W])) else $error("slew");
  AST_RST: assert property (disable iff (1'b0) rst |=>
    !output_protocol_select && output_slew_select == SLEW_RST
    && !overvoltage_threshold_select) else $error("reset");
  AST_VALID: assert property (field_valid |=> output_valid)
    else $error("valid");
  AST_SUM: assert property (field_valid && sum[12] == sum[11] |=>
    output_level == $past(sum[11:0])) else $error("sum");
  AST_SATP: assert property (field_valid && sum[12:11] == 2'h1 |=>
    output_level == 12'h7FF) else $error("sat hi");
  AST_SATN: assert property (field_valid && sum[12:11] == 2'h2 |=>
    output_level == 12'h800) else $error("sat lo");
endmodule : socf_chk
bind socf_cfg socf_chk chk_u (.*);

// ===== verification/socf_path.sv
`timescale 1ns/1ps
module socf_path (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [11:0] val,
  output logic [11:0] field_response,
  output logic field_valid
);
  initial field_valid = 1'b0;
  initial field_response = 12'h000;
  // between samples the line inverts every cycle, so stale data is not held steady
  always @(posedge ref_clk) begin
    field_valid <= go;
    field_response <= go ? val : ~field_response;
  end
endmodule : socf_path

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top import socf_pkg::*; ;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, go = 1'b0, pready, pslverr, field_valid, output_valid;
  logic output_protocol_select, overvoltage_threshold_select, err;
  logic [2:0] output_slew_select;
  logic [11:0] paddr = 12'h000, val = 12'h000, factory_quiescent = 12'h100;
  logic [11:0] field_response, output_level;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  // address, write data, then expected {protocol, slew, threshold} pins
  logic [48:0] rows [4] = '{{SLEW_ADDR, 32'h001C0000, 5'h0E},
    {SLEW_ADDR, 32'h00040000, 5'h02}, {MODE_ADDR, 32'h00000408, 5'h13},
    {MODE_ADDR, 32'h00000008, 5'h12}};
  int n_errors = 0, num_checks = 0;
  always #2 ref_clk = ~ref_clk;
  socf_path path_u (.*);
  socf_cfg dut_u (.*);
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // one apb transfer; an idle cycle after it keeps drives one per step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk) penable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 8) n_errors++;
    if (i == 8) report_and_stop;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task smp(input logic [11:0] v, input logic [11:0] e);
    go <= 1'b1;
    val <= v;
    @(posedge ref_clk) go <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("valid", output_valid, 1'b1);
    chk("level", output_level, e);
  endtask : smp
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (rows[k]) begin
      apb(1'b1, rows[k][48:37], rows[k][36:5]);
      apb(1'b0, rows[k][48:37], 32'h0);
      chk("readback", rd, rows[k][36:5]);
      chk("pins", {output_protocol_select, output_slew_select,
        overvoltage_threshold_select}, rows[k][4:0]);
    end
    rst <= 1'b1;
    @(posedge ref_clk) rst <= 1'b0;
    @(posedge ref_clk);
    chk("pins", {output_protocol_select, output_slew_select,
      overvoltage_threshold_select}, 32'h0);
    apb(1'b0, QTRIM_ADDR, 32'h0);
    chk("trim", rd, 32'h7FF);
    chk("okay", err, 1'b0);
    apb(1'b0, 12'hFF0, 32'h0);
    chk("slverr", err, 1'b1);
    chk("unmapped", rd, 32'h0);
    smp(12'h050, 12'h150);
    apb(1'b1, QTRIM_ADDR, 32'h800);
    apb(1'b0, QSET_ADDR, 32'h0);
    chk("trim set", rd, 32'h1);
    smp(12'h100, 12'h900);
    smp(12'h800, 12'h800);
    apb(1'b1, QTRIM_ADDR, 32'h7FF);
    smp(12'h7FF, 12'h7FF);
    apb(1'b1, QSET_ADDR, 32'h0);
    apb(1'b0, QSET_ADDR, 32'h0);
    chk("trim clear", rd, 32'h0);
    smp(12'h000, 12'h100);
    report_and_stop;
  end
endmodule : tb_top

// ===== verilog/socf_cfg.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - protocol bit 0 selects SENT, 1 PWM
// - quiescent trim is 12-bit two's complement
// - 7FF near +50% FS, 800 is -50%
// - factory quiescent used until trim set
// - trim added to output as baseline
// - 3-bit slew code, 000 fastest default
// - threshold bit 0 is 19.3V, 1 6.5V
module socf_cfg
  import socf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] factory_quiescent,
  input wire logic [11:0] field_response,
  input wire logic field_valid,
  output logic [11:0] output_level,
  output logic output_valid,
  output logic output_protocol_select,
  output logic [2:0] output_slew_select,
  output logic overvoltage_threshold_select
);
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // registers are aligned words, so the low two address bits and the
  // byte lanes play no part in the decode
  logic [11:0] word_addr;
  logic hit_slew;
  logic hit_mode;
  logic hit_qtrim;
  logic hit_qset;
  logic mapped;
  // first access cycle of a transfer, while pready is still low
  logic access;
  logic wr_go;
  logic rd_go;
  // configuration state kept beside the output pins
  logic [11:0] trim;
  logic trim_set;
  socf_proto_t proto;
  // read words, each zero outside its own fields
  logic [31:0] rd_slew_word;
  logic [31:0] rd_mode_word;
  logic [31:0] rd_trim_word;
  logic [31:0] rd_set_word;
  logic [31:0] next_prdata;
  // quiescent datapath
  logic [11:0] base;
  logic [12:0] resp_ext;
  logic [12:0] base_ext;
  logic [12:0] sum;
  logic over_pos;
  logic over_neg;
  logic [11:0] sat;

  // word compare against the map
  assign word_addr = paddr & ADDR_MASK;
  assign hit_slew = (word_addr == SLEW_ADDR);
  assign hit_mode = (word_addr == MODE_ADDR);
  assign hit_qtrim = (word_addr == QTRIM_ADDR);
  assign hit_qset = (word_addr == QSET_ADDR);
  assign mapped = hit_slew | hit_mode | hit_qtrim | hit_qset;

  // single wait state: the write lands and read data loads on the edge
  // that ends the first access cycle; the master keeps the request up
  // one more cycle while pready stands, which changes nothing
  assign access = psel & penable & ~pready;
  assign wr_go = access & pwrite;
  assign rd_go = access & ~pwrite;

  // ready pulse, one cycle per access; masking with ~pready keeps a
  // held request from being taken twice
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= access;
    end
  end

  // error pulse rides with ready when no register answers the word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access & ~mapped;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // gate ramp code for the output driver; 000 gives the fastest edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      output_slew_select <= SLEW_RST;
    end else if (wr_go && hit_slew) begin
      output_slew_select <= pwdata[SLEW_LSB +: SLEW_W];
    end
  end

  // normal output protocol; the enum copy feeds read back while the
  // pin copy leaves straight from its own flip-flop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      proto <= SOCF_SENT;
      output_protocol_select <= PROTO_RST;
    end else if (wr_go && hit_mode) begin
      proto <= pwdata[PROTO_BIT] ? SOCF_PWM : SOCF_SENT;
      output_protocol_select <= pwdata[PROTO_BIT];
    end
  end

  // lockout threshold shares the word with the protocol bit, so a write
  // to that word always sets both; software must keep the other bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      overvoltage_threshold_select <= OVLO_RST;
    end else if (wr_go && hit_mode) begin
      overvoltage_threshold_select <= pwdata[OVLO_BIT];
    end
  end

  // trim value; the datapath keeps the factory baseline until trim_set rises,
  // so its reset code reaches it only if bit 0 of the set word raises trim_set first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trim <= QTRIM_RST;
    end else if (wr_go && hit_qtrim) begin
      trim <= pwdata[QTRIM_W-1:0];
    end
  end

  // trim_set: a trim write raises it, bit 0 of the set word writes it;
  // one word is addressed per cycle, so the two never meet
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trim_set <= 1'b0;
    end else if (wr_go && hit_qtrim) begin
      trim_set <= 1'b1;
    end else if (wr_go && hit_qset) begin
      trim_set <= pwdata[0];
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // each word built apart, unused bits tied to zero
  always_comb begin
    rd_slew_word = 32'h0000_0000;
    rd_slew_word[SLEW_LSB +: SLEW_W] = output_slew_select;
  end

  // protocol and threshold sit in one word
  always_comb begin
    rd_mode_word = 32'h0000_0000;
    rd_mode_word[PROTO_BIT] = (proto == SOCF_PWM);
    rd_mode_word[OVLO_BIT] = overvoltage_threshold_select;
  end

  // trim reads back raw, whether or not it is in use
  always_comb begin
    rd_trim_word = 32'h0000_0000;
    rd_trim_word[QTRIM_W-1:0] = trim;
  end

  // set flag in bit 0 so software can see which baseline is live
  always_comb begin
    rd_set_word = 32'h0000_0000;
    rd_set_word[0] = trim_set;
  end

  // select by word; an unmapped word reads as zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_slew) begin
      next_prdata = rd_slew_word;
    end else if (hit_mode) begin
      next_prdata = rd_mode_word;
    end else if (hit_qtrim) begin
      next_prdata = rd_trim_word;
    end else if (hit_qset) begin
      next_prdata = rd_set_word;
    end
  end

  // read data loaded only by a read, then held until the next one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_go) begin
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // quiescent baseline added to the field response
  // ---------------------------------------------------------------
  // factory baseline until software has set the trim
  assign base = trim_set ? trim : factory_quiescent;

  // one extra sign bit on each operand so the sum itself cannot wrap
  assign resp_ext = {field_response[11], field_response};
  assign base_ext = {base[11], base};
  assign sum = resp_ext + base_ext;

  // overflow shows as the two top bits of the sum disagreeing
  assign over_pos = ~sum[12] & sum[11];
  assign over_neg = sum[12] & ~sum[11];

  // clamp at the range ends rather than wrap: a wrapped level would
  // jump across the whole output span for a small overshoot
  always_comb begin
    if (over_pos) begin
      sat = SIG_MAX[11:0];
    end else if (over_neg) begin
      sat = SIG_MIN[11:0];
    end else begin
      sat = sum[11:0];
    end
  end

  // qualifier delayed one cycle to match the registered level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      output_valid <= 1'b0;
    end else begin
      output_valid <= field_valid;
    end
  end

  // level holds between samples; the input line then carries no data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      output_level <= 12'h000;
    end else if (field_valid) begin
      output_level <= sat;
    end
  end

endmodule : socf_cfg

// ===== verilog/socf_pkg.sv
package socf_pkg;
  // ---------------------------------------------------------------
  // register map (printed offsets are word indices)
  // ---------------------------------------------------------------
  localparam logic [7:0] SLEW_IDX = 8'h07;
  localparam logic [7:0] MODE_IDX = 8'h1C;
  localparam logic [7:0] QTRIM_IDX = 8'h1D;
  localparam logic [7:0] QSET_IDX = 8'h1E;
  localparam logic [11:0] ADDR_MASK = 12'hFFC;
  localparam logic [11:0] SLEW_ADDR = {2'h0, SLEW_IDX, 2'h0};
  localparam logic [11:0] MODE_ADDR = {2'h0, MODE_IDX, 2'h0};
  localparam logic [11:0] QTRIM_ADDR = {2'h0, QTRIM_IDX, 2'h0};
  localparam logic [11:0] QSET_ADDR = {2'h0, QSET_IDX, 2'h0};
  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int SLEW_LSB = 18;
  localparam int SLEW_W = 3;
  localparam int OVLO_BIT = 10;
  localparam int PROTO_BIT = 3;
  localparam int QTRIM_W = 12;
  localparam int SIG_W = 13;
  // ---------------------------------------------------------------
  // reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] SLEW_RST = 3'h0;
  localparam logic PROTO_RST = 1'b0;
  localparam logic OVLO_RST = 1'b0;
  localparam logic [11:0] QTRIM_RST = 12'h7FF;
  localparam logic PROTO_SENT = 1'b0;
  localparam logic PROTO_PWM = 1'b1;
  localparam logic OVLO_HIGH = 1'b0;  // about 19.3 V
  localparam logic OVLO_LOW = 1'b1;   // about 6.5 V
  localparam logic [12:0] SIG_MAX = 13'h07FF;
  localparam logic [12:0] SIG_MIN = 13'h1800;
  typedef enum logic {SOCF_SENT, SOCF_PWM} socf_proto_t;
endpackage : socf_pkg
